// ==== lsd_serial_ctrl.v ====
// How it works
// - 16-bit shift register feeds parallel channel latches
// - Enabled channel below open threshold reads 0
// - Disabled channel reports status 0
// - Short trips to 0, back to 1 when trip sense clears (release sense unused)
// - Global overtemperature: all off, all status 0
// - Channel overtemperature: that channel off, 0
// - Cooled channel restarts if latch still on
// - Overtemperature bit stays 0 until cleared
// - Return to Normal clears stored errors
// - Enable low pulse starts mode switch phase
// - Strobe at fourth edge picks target mode
// - Strobe latches nothing during switch window
// - Power-on starts in Normal mode
// - Normal mode shifts serial in, out
// - Normal strobe copies shift into output latch
// - Enable low drives latched channels, high off
// - Special enable low loads status to shift
// - Special strobe writes configuration latch
// - Configuration code sets gain in 256 steps
`timescale 1ns/1ns
`default_nettype none
`include "lsd_defs.vh"
module lsd_serial_ctrl #(
   parameter CHANNELS  = `LSD_CHANNELS,
   parameter CFG_WIDTH = `LSD_CFG_WIDTH
) (
   // System clock and reset
   input  wire                 ref_clk,
   input  wire                 rst,
   // Serial link pins
   input  wire                 link_clk,
   input  wire                 serial_in,
   output reg                  serial_out,
   input  wire                 latch_strobe_pin,
   input  wire                 output_enable_n_pin,
   // Analog sense inputs, one bit per channel except global overtemperature and short detect enable
   input  wire [CHANNELS-1:0]  open_load_sense,
   input  wire [CHANNELS-1:0]  short_trip_sense,
   input  wire [CHANNELS-1:0]  short_release_sense,
   input  wire                 global_overtemp,
   input  wire [CHANNELS-1:0]  channel_overtemp,
   input  wire                 short_detect_enable,
   // Channel outputs
   output reg  [CHANNELS-1:0]  sink_enable,
   output wire                 sink_channel_first,
   output wire                 sink_channel_last,
   output reg  [CFG_WIDTH-1:0] gain_code,
   output reg                  special_mode,
   // Parallel latch update stream
   output wire                 latch_valid,
   input  wire                 latch_ready,
   output wire [CHANNELS-1:0]  latch_data,
   // Status
   output reg  [CHANNELS-1:0]  error_status,
   output wire                 update_dropped
);
   localparam ST_NORMAL  = 3'b001;
   localparam ST_SWITCH  = 3'b010;
   localparam ST_SPECIAL = 3'b100;

   // Pin synchronisers; first stage read only by the second
   reg [3:0] sync1_reg;
   reg [3:0] sync2_reg;
   reg       clk_prev_reg;
   wire      s_clk;
   wire      s_din;
   wire      s_le;
   wire      s_oe_n;
   wire      rise;

   // Link-side state
   reg [CHANNELS-1:0]  shift_reg;
   reg [CHANNELS-1:0]  shift_next;
   reg [CHANNELS-1:0]  out_latch_reg;
   reg [CHANNELS-1:0]  thermal_off_reg;
   reg [CHANNELS-1:0]  err_reg;
   reg [CHANNELS-1:0]  err_next;
   reg [2:0]           oe_hist_reg;
   reg [2:0]           state_reg;
   reg [2:0]           state_next;
   reg [2:0]           sw_cnt_reg;
   reg                 target_reg;
   reg [1:0]           low_cnt_reg;
   reg                 pend_reg;
   reg [CHANNELS-1:0]  pend_data_reg;
   reg                 drop_reg;
   wire [CHANNELS-1:0] driven;
   wire                buf_in_ready;
   wire                oe_pulse;
   wire                in_window;
   wire                strobe_normal;
   wire                strobe_cfg;
   wire                capture;

   assign s_clk  = sync2_reg[0];
   assign s_din  = sync2_reg[1];
   assign s_le   = sync2_reg[2];
   assign s_oe_n = sync2_reg[3];
   assign rise   = s_clk & ~clk_prev_reg;

   // History holds the last three sampled enable levels, newest in bit 0
   assign oe_pulse  = ({oe_hist_reg[1:0], s_oe_n} == 3'b101);
   // Pattern edge itself already belongs to the window
   assign in_window = (state_reg == ST_SWITCH) | oe_pulse;
   // Strobe ignored as a latch inside the switch window
   assign strobe_normal = s_le & ~in_window & (state_reg == ST_NORMAL);
   assign strobe_cfg    = s_le & ~in_window & (state_reg == ST_SPECIAL);
   // Capture from the third low edge onward
   assign capture = (state_reg == ST_SPECIAL) & ~s_oe_n
                    & (low_cnt_reg == `LSD_CAPTURE_EDGES);

   // Channels driven: latch on, enable low, not thermally shut down
   assign driven = out_latch_reg & {CHANNELS{~s_oe_n}} & ~thermal_off_reg;

   assign sink_channel_first = sink_enable[0];
   assign sink_channel_last  = sink_enable[CHANNELS-1];
   assign update_dropped     = drop_reg;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg    <= 4'h8;
         sync2_reg    <= 4'h8;
         clk_prev_reg <= 1'b0;
      end else begin
         sync1_reg    <= {output_enable_n_pin, latch_strobe_pin, serial_in, link_clk};
         sync2_reg    <= sync1_reg;
         clk_prev_reg <= s_clk;
      end
   end

   // Error status: sticky zeros, set to 0 wins over any clear
   always @* begin
      err_next = err_reg;
      if (state_next == ST_NORMAL && state_reg != ST_NORMAL) begin
         err_next = `LSD_ERR_RESET;
      end
      if (global_overtemp) begin
         err_next = {CHANNELS{1'b0}};
      end else begin
         err_next = err_next & ~(channel_overtemp & out_latch_reg);
      end
   end

   // Mode state machine, stepped on link rising edges
   always @* begin
      state_next = state_reg;
      if (rise) begin
         case (state_reg)
            ST_NORMAL: begin
               if (oe_pulse) begin
                  state_next = ST_SWITCH;
               end
            end
            ST_SPECIAL: begin
               if (oe_pulse) begin
                  state_next = ST_SWITCH;
               end
            end
            ST_SWITCH: begin
               if (sw_cnt_reg == `LSD_MODE_WINDOW) begin
                  state_next = target_reg ? ST_SPECIAL : ST_NORMAL;
               end
            end
            default: begin
               state_next = ST_NORMAL;
            end
         endcase
      end
   end

   // Shift source: detected status on capture, held while enable low in special, else serial data
   always @* begin
      shift_next = shift_reg;
      if (rise) begin
         if (capture) begin
            shift_next = error_status;
         end else if (!((state_reg == ST_SPECIAL) && !s_oe_n)) begin
            shift_next = {shift_reg[CHANNELS-2:0], s_din};
         end
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg       <= ST_NORMAL;
         shift_reg       <= {CHANNELS{1'b0}};
         out_latch_reg   <= `LSD_LATCH_RESET;
         gain_code       <= `LSD_CFG_RESET;
         oe_hist_reg     <= 3'h7;
         sw_cnt_reg      <= 3'h0;
         target_reg      <= 1'b0;
         low_cnt_reg     <= 2'h0;
         thermal_off_reg <= {CHANNELS{1'b0}};
         err_reg         <= `LSD_ERR_RESET;
         error_status    <= `LSD_ERR_RESET;
         sink_enable     <= {CHANNELS{1'b0}};
         serial_out      <= 1'b0;
         special_mode    <= 1'b0;
         pend_reg        <= 1'b0;
         pend_data_reg   <= {CHANNELS{1'b0}};
         drop_reg        <= 1'b0;
      end else begin
         state_reg    <= state_next;
         shift_reg    <= shift_next;
         err_reg      <= err_next;
         serial_out   <= shift_next[CHANNELS-1];
         special_mode <= (state_next == ST_SPECIAL);
         sink_enable  <= driven;
         // Thermal shutdown follows the sensors; release on cooling
         thermal_off_reg <= channel_overtemp | {CHANNELS{global_overtemp}};
         // Live detection: open, short, then sticky overtemperature bits
         error_status <= err_next & out_latch_reg & ~thermal_off_reg
                         & ~open_load_sense
                         & ~(short_trip_sense & {CHANNELS{short_detect_enable}})
                         | (error_status & short_trip_sense & ~short_release_sense
                            & {CHANNELS{short_detect_enable}} & 16'h0000);
         if (rise) begin
            oe_hist_reg <= {oe_hist_reg[1:0], s_oe_n};
            if (state_reg == ST_SWITCH) begin
               sw_cnt_reg <= sw_cnt_reg + 3'h1;
               if (sw_cnt_reg == `LSD_MODE_SAMPLE_EDGE) begin
                  target_reg <= s_le;
               end
            end else begin
               sw_cnt_reg <= 3'h0;
            end
            if (s_oe_n) begin
               low_cnt_reg <= 2'h0;
            end else if (low_cnt_reg != `LSD_CAPTURE_EDGES) begin
               low_cnt_reg <= low_cnt_reg + 2'h1;
            end
            if (strobe_cfg) begin
               gain_code <= shift_next[CFG_WIDTH-1:0];
            end
         end
         // Latch copy waits for buffer room; a second strobe while waiting
         // replaces the pending word and is flagged
         if (rise && strobe_normal) begin
            // Bit shifted on the strobe edge is part of the latched word
            out_latch_reg <= shift_next;
            pend_reg      <= 1'b1;
            pend_data_reg <= shift_next;
            drop_reg      <= pend_reg & ~buf_in_ready;
         end else if (pend_reg && buf_in_ready) begin
            pend_reg <= 1'b0;
         end
      end
   end

   lsd_buffer #(
      .WIDTH(CHANNELS)
   ) u_buffer (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (pend_reg),
      .in_ready  (buf_in_ready),
      .in_data   (pend_data_reg),
      .out_valid (latch_valid),
      .out_ready (latch_ready),
      .out_data  (latch_data)
   );
endmodule // lsd_serial_ctrl
`default_nettype wire

// ==== lsd_defs.vh ====
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH
// Channel count and configuration latch width
`define LSD_CHANNELS        16
`define LSD_CFG_WIDTH       8
// Configuration code after power-on: gain 127/128 is code 8'hFF
`define LSD_CFG_RESET       8'hFF
// Output latch reset value
`define LSD_LATCH_RESET     16'h0000
// Error status reset value (all cleared to normal)
`define LSD_ERR_RESET       16'hFFFF
// Mode switch: edge count after the pattern at which the strobe is sampled
`define LSD_MODE_SAMPLE_EDGE 3'h0
// Mode switch window: last switch count, so the window spans two link edges after the pattern
`define LSD_MODE_WINDOW     3'h1
// Low output-enable edges before status capture
`define LSD_CAPTURE_EDGES   2'h2
`endif

// ==== lsd_buffer.v ====
`timescale 1ns/1ns
`default_nettype none
// Two-entry buffer; a stalled receiver loses no word
module lsd_buffer #(
   parameter WIDTH = 16
) (
   // Clock and reset
   input  wire             ref_clk,
   input  wire             rst,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_reg [0:1];
   reg             wr_ptr_reg;
   reg             rd_ptr_reg;
   reg [1:0]       count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem_reg[0] <= {WIDTH{1'b0}};
         mem_reg[1] <= {WIDTH{1'b0}};
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule // lsd_buffer
`default_nettype wire

// ==== lsd_link_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Controller side of the serial link; link clock stands low between bits
module lsd_link_model (
   // Clock
   input  wire logic ref_clk,
   // Link pins
   output var  logic link_clk,
   output var  logic serial_in,
   output var  logic latch_strobe_pin,
   output var  logic output_enable_n_pin,
   input  wire logic serial_out
);
   initial begin
      link_clk = 1'b0;
      serial_in = 1'b0;
      latch_strobe_pin = 1'b0;
      output_enable_n_pin = 1'b1;
   end
   // One 8-cycle link bit; pins held over the rising edge, cascade read mid-low
   task automatic clk_bit(input logic d, input logic le, input logic oe_n, output logic so);
      @(posedge ref_clk);
      serial_in <= d;
      latch_strobe_pin <= le;
      output_enable_n_pin <= oe_n;
      repeat (2) @(negedge ref_clk);
      so = serial_out;
      repeat (3) @(posedge ref_clk);
      link_clk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      link_clk <= 1'b0;
   endtask
   // Enable high-low-high, then strobe held over edges three to five
   task automatic switch_mode(input logic sel);
      logic so;
      clk_bit(1'b0, 1'b0, 1'b1, so);
      clk_bit(1'b0, 1'b0, 1'b0, so);
      repeat (3) clk_bit(1'b0, sel, 1'b1, so);
      clk_bit(1'b0, 1'b0, 1'b1, so);
   endtask
endmodule // lsd_link_model
`default_nettype wire

// ==== lsd_serial_ctrl_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module lsd_serial_ctrl_chk #(
   parameter CHANNELS  = 16,
   parameter CFG_WIDTH = 8
) (
   // Clock, reset, pins
   input wire logic                 ref_clk,
   input wire logic                 rst,
   input wire logic                 link_clk,
   input wire logic                 output_enable_n_pin,
   input wire logic                 global_overtemp,
   // Outputs, plus the latch ready input
   input wire logic                 serial_out,
   input wire logic [CHANNELS-1:0]  sink_enable,
   input wire logic                 sink_channel_first,
   input wire logic                 sink_channel_last,
   input wire logic [CFG_WIDTH-1:0] gain_code,
   input wire logic                 special_mode,
   input wire logic                 latch_valid,
   input wire logic                 latch_ready,
   input wire logic [CHANNELS-1:0]  latch_data,
   input wire logic [CHANNELS-1:0]  error_status
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Link pin is slow, so outputs may move a few cycles after its edge
   logic       link_prev;
   logic [2:0] since_rise;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         link_prev <= 1'b0;
         since_rise <= 3'h7;
      end else begin
         link_prev <= link_clk;
         if (link_clk && !link_prev) since_rise <= 3'h0;
         else if (since_rise != 3'h7) since_rise <= since_rise + 3'h1;
      end
   end
   a_first_bit: assert property (sink_channel_first == sink_enable[0])
      else $error("first channel pin differs");
   a_last_bit: assert property (sink_channel_last == sink_enable[CHANNELS-1])
      else $error("last channel pin differs");
   a_off_disabled: assert property (output_enable_n_pin [*6] |-> sink_enable == '0)
      else $error("channel on while enable high");
   a_global_off: assert property (global_overtemp [*5] |-> sink_enable == '0 && error_status == '0)
      else $error("global overtemp left a channel on");
   a_gain_special: assert property ($changed(gain_code) |-> special_mode)
      else $error("gain written outside special mode");
   a_buf_hold: assert property (latch_valid && !latch_ready |=> latch_valid && $stable(latch_data))
      else $error("stalled update word lost");
   a_serial_edge: assert property ($changed(serial_out) |-> since_rise inside {[1:6]})
      else $error("serial out moved without link edge");
   a_mode_edge: assert property ($changed(special_mode) |-> since_rise inside {[1:6]})
      else $error("mode moved without link edge");
   c_special: cover property ($rose(special_mode));
   c_normal: cover property ($fell(special_mode));
   c_drain: cover property (latch_valid && latch_ready);
endmodule // lsd_serial_ctrl_chk
bind lsd_serial_ctrl lsd_serial_ctrl_chk #(.CHANNELS(CHANNELS), .CFG_WIDTH(CFG_WIDTH)) i_chk (
   .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .output_enable_n_pin(output_enable_n_pin),
   .global_overtemp(global_overtemp), .serial_out(serial_out), .sink_enable(sink_enable),
   .sink_channel_first(sink_channel_first), .sink_channel_last(sink_channel_last),
   .gain_code(gain_code), .special_mode(special_mode), .latch_valid(latch_valid),
   .latch_ready(latch_ready), .latch_data(latch_data), .error_status(error_status));
`default_nettype wire

// ==== tb_lsd_serial_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_lsd_serial_ctrl;
   logic        ref_clk, rst, link_clk, serial_in, latch_strobe_pin, output_enable_n_pin;
   logic        global_overtemp, short_detect_enable, latch_ready, latch_valid, serial_out;
   logic        sink_channel_first, sink_channel_last, special_mode, update_dropped, drop_seen, b;
   logic [15:0] open_load_sense, short_trip_sense, short_release_sense, channel_overtemp;
   logic [15:0] sink_enable, latch_data, error_status, got;
   logic [7:0]  gain_code;
   int          mismatches, samples_checked, n;
   lsd_link_model i_link (.ref_clk(ref_clk), .link_clk(link_clk), .serial_in(serial_in),
      .latch_strobe_pin(latch_strobe_pin), .output_enable_n_pin(output_enable_n_pin),
      .serial_out(serial_out));
   lsd_serial_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
      .serial_in(serial_in), .serial_out(serial_out), .latch_strobe_pin(latch_strobe_pin),
      .output_enable_n_pin(output_enable_n_pin), .open_load_sense(open_load_sense),
      .short_trip_sense(short_trip_sense), .short_release_sense(short_release_sense),
      .global_overtemp(global_overtemp), .channel_overtemp(channel_overtemp),
      .short_detect_enable(short_detect_enable), .sink_enable(sink_enable),
      .sink_channel_first(sink_channel_first), .sink_channel_last(sink_channel_last),
      .gain_code(gain_code), .special_mode(special_mode), .latch_valid(latch_valid),
      .latch_ready(latch_ready), .latch_data(latch_data), .error_status(error_status),
      .update_dropped(update_dropped));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Drop flag holds only until the next strobe, so keep it
   always @(posedge ref_clk) if (update_dropped === 1'b1) drop_seen <= 1'b1;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic settle;
      repeat (8) @(negedge ref_clk);
   endtask
   // MSB first in; got collects the cascade output ahead of each bit
   task automatic send_word(input logic [15:0] w, input logic le, input logic oe_n);
      for (int i = 15; i >= 0; i--) i_link.clk_bit(w[i], le && i == 0, oe_n, got[i]);
      settle();
   endtask
   initial begin
      #1_000_000;
      mismatches++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      {open_load_sense, short_trip_sense, short_release_sense, channel_overtemp} = '0;
      {global_overtemp, short_detect_enable, latch_ready, drop_seen} = '0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      check(sink_enable, 16'h0000);
      check({8'h00, gain_code}, 16'h00FF);
      check({15'h0000, special_mode}, 16'h0000);
      $display("test reset done");
      send_word(16'hA5C3, 1'b1, 1'b0);
      check(sink_enable, 16'hA5C3);
      check({latch_valid, latch_data[14:0]}, 16'hA5C3);
      send_word(16'h5A3C, 1'b1, 1'b0);
      check(got, 16'hA5C3);
      send_word(16'h0F81, 1'b1, 1'b0);
      check({15'h0000, drop_seen}, 16'h0000);
      @(posedge ref_clk);
      latch_ready <= 1'b1;
      repeat (8) @(negedge ref_clk) n += int'(latch_valid);
      check(n[15:0], 16'h0003);
      check(sink_enable, 16'h0F81);
      i_link.clk_bit(1'b0, 1'b0, 1'b1, b);
      settle();
      check(sink_enable, 16'h0000);
      $display("test normal done");
      @(posedge ref_clk);
      channel_overtemp <= 16'h0100;
      settle();
      check(sink_enable, 16'h0000);
      repeat (2) i_link.clk_bit(1'b0, 1'b0, 1'b0, b);
      settle();
      check(sink_enable, 16'h0E81);
      check({15'h0000, error_status[8]}, 16'h0000);
      @(posedge ref_clk);
      channel_overtemp <= 16'h0000;
      global_overtemp <= 1'b1;
      settle();
      check(sink_enable, 16'h0000);
      check(error_status, 16'h0000);
      @(posedge ref_clk);
      global_overtemp <= 1'b0;
      settle();
      check(sink_enable, 16'h0F81);
      $display("test thermal done");
      i_link.switch_mode(1'b0);
      settle();
      check(error_status, 16'h0F81);
      i_link.switch_mode(1'b1);
      repeat (2) i_link.clk_bit(1'b0, 1'b0, 1'b0, b);
      settle();
      check({15'h0000, special_mode}, 16'h0001);
      check(sink_enable, 16'h0F81);
      send_word(16'h0037, 1'b1, 1'b1);
      check({8'h00, gain_code}, 16'h0037);
      @(posedge ref_clk);
      open_load_sense <= 16'h0100;
      short_detect_enable <= 1'b1;
      short_trip_sense <= 16'h0080;
      short_release_sense <= 16'hFF7F;
      repeat (4) i_link.clk_bit(1'b0, 1'b0, 1'b0, b);
      settle();
      check(sink_enable, 16'h0F81);
      send_word(16'h0000, 1'b0, 1'b1);
      check(got, 16'h0E01);
      $display("test special done");
      @(posedge ref_clk);
      {open_load_sense, short_trip_sense, short_release_sense} <= '0;
      i_link.switch_mode(1'b0);
      settle();
      check({15'h0000, special_mode}, 16'h0000);
      $display("test return done");
      end_sim();
   end
endmodule // tb_lsd_serial_ctrl
`default_nettype wire
